// [design/uft_top.sv]
`timescale 1ns/1ps
module uft_top (
    input  wire logic                       clk_i,
    input  wire logic                       rst_b_i,
    input  wire logic [1:0]                 rx_request_threshold_i,
    input  wire logic [1:0]                 tx_request_threshold_i,
    input  wire logic                       clear_to_send_check_i,
    input  wire logic                       auto_flow_enable_i,
    input  wire logic [uft_pkg::LVL_W-1:0]  rx_level_i,
    input  wire logic [uft_pkg::LVL_W-1:0]  tx_free_i,
    input  wire logic                       cts_b_i,
    input  wire logic                       tx_valid_i,
    input  wire logic [uft_pkg::BYTE_W-1:0] tx_data_i,
    output logic                            tx_ready_o,
    input  wire logic                       tx_shift_ready_i,
    output logic                            tx_start_o,
    output logic [uft_pkg::BYTE_W-1:0]      tx_byte_o,
    output logic                            rx_irq_req_o,
    output logic                            rx_dma_req_o,
    output logic                            tx_irq_req_o,
    output logic                            tx_dma_req_o
);
    import uft_pkg::*;

    // ==========================================================
    // threshold decode, shared by both directions
    function automatic logic [LVL_W-1:0] thr_bytes(input logic [1:0] code);
        unique case (code)
            THR_CODE_ONE:   thr_bytes = THR_ONE;
            THR_CODE_FOUR:  thr_bytes = THR_FOUR;
            THR_CODE_EIGHT: thr_bytes = THR_EIGHT;
            THR_CODE_TWELVE: thr_bytes = THR_TWELVE;
        endcase
    endfunction

    wire rx_met      = rx_level_i >= thr_bytes(rx_request_threshold_i);
    wire tx_met      = tx_free_i >= thr_bytes(tx_request_threshold_i);
    // code 01 is interrupt-only on receive
    wire rx_dma_code = rx_request_threshold_i != THR_CODE_FOUR;
    // only the two large codes may drive transmit dma
    wire tx_dma_code = tx_request_threshold_i[1];

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_irq_req_o <= REQ_RST;
            rx_dma_req_o <= REQ_RST;
            tx_irq_req_o <= REQ_RST;
            tx_dma_req_o <= REQ_RST;
        end else begin
            rx_irq_req_o <= rx_met;
            rx_dma_req_o <= rx_met & rx_dma_code;
            tx_irq_req_o <= tx_met;
            tx_dma_req_o <= tx_met & tx_dma_code;
        end
    end

    // ==========================================================
    // clear-to-send synchroniser
    logic cts_meta_b;
    logic cts_sync_b;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cts_meta_b <= 1'b1;
            cts_sync_b <= 1'b1;
        end else begin
            cts_meta_b <= cts_b_i;
            cts_sync_b <= cts_meta_b;
        end
    end

    // ==========================================================
    // transmit byte path
    uft_buf_if tx_buf ();

    uft_buf u_buf (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .bus     (tx_buf.buffer)
    );

    // autoflow owns the handshake when on, so the check bit is dropped
    wire cts_gate = clear_to_send_check_i & ~auto_flow_enable_i;
    wire cts_ok   = ~cts_gate | ~cts_sync_b;
    // one launch per shifter-ready window; the pulse blocks a repeat
    // while the shifter's ready has not yet fallen
    wire launch   = tx_buf.out_valid & tx_shift_ready_i & cts_ok & ~tx_start_o;

    assign tx_buf.in_valid  = tx_valid_i;
    assign tx_buf.in_data   = tx_data_i;
    assign tx_buf.out_ready = launch;
    assign tx_ready_o       = tx_buf.in_ready;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_start_o <= REQ_RST;
            tx_byte_o  <= BYTE_RST;
        end else begin
            tx_start_o <= launch;
            if (launch) begin
                tx_byte_o <= tx_buf.out_data;
            end
        end
    end

    // ==========================================================
    // checks
    sequence s_cts_blocked;
        clear_to_send_check_i && !auto_flow_enable_i && cts_sync_b;
    endsequence

    sequence s_free_launch;
        auto_flow_enable_i && tx_buf.out_valid && tx_shift_ready_i && !tx_start_o;
    endsequence

    a_rx_four_irq : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        rx_request_threshold_i == THR_CODE_FOUR |=>
            !rx_dma_req_o && rx_irq_req_o == ($past(rx_level_i) >= 5'h04))
        else $error("rx code 01 request wrong");
    a_rx_big_both : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        rx_request_threshold_i[1] |=> rx_dma_req_o == rx_irq_req_o &&
            rx_irq_req_o == ($past(rx_level_i) >= ($past(rx_request_threshold_i[0]) ? 5'h0c : 5'h08)))
        else $error("rx code 10/11 request wrong");
    a_rx_one_both : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        rx_request_threshold_i == THR_CODE_ONE && rx_level_i != 5'h00 |=>
            rx_irq_req_o && rx_dma_req_o)
        else $error("rx code 00 request missing");
    a_tx_small_irq : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !tx_request_threshold_i[1] |=> !tx_dma_req_o &&
            tx_irq_req_o == ($past(tx_free_i) >= ($past(tx_request_threshold_i[0]) ? 5'h04 : 5'h01)))
        else $error("tx code 00/01 request wrong");
    a_tx_big_both : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        tx_request_threshold_i[1] |=> tx_dma_req_o == tx_irq_req_o &&
            tx_irq_req_o == ($past(tx_free_i) >= ($past(tx_request_threshold_i[0]) ? 5'h0c : 5'h08)))
        else $error("tx code 10/11 request wrong");
    a_cts_hold_byte : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_cts_blocked |=> !tx_start_o)
        else $error("byte launched while clear-to-send negated");
    a_afe_ignore_cts : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_free_launch |=> tx_start_o ##1 !tx_start_o)
        else $error("autoflow launch blocked");
    a_req_drop_fast : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        rx_level_i < thr_bytes(rx_request_threshold_i) |=> !rx_irq_req_o && !rx_dma_req_o)
        else $error("rx request held after condition lapsed");

    // ==========================================================
    // request follow-up and launch checks
    // a request must rise one cycle after its condition is met
    sequence s_rx_met;
        rx_level_i >= thr_bytes(rx_request_threshold_i);
    endsequence

    sequence s_tx_met;
        tx_free_i >= thr_bytes(tx_request_threshold_i);
    endsequence

    a_rx_rise_fast : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_rx_met |=>
            rx_irq_req_o)
        else $error("rx request late after condition met");

    a_tx_rise_fast : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_tx_met |=>
            tx_irq_req_o)
        else $error("tx request late after condition met");

    a_tx_drop_fast : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        tx_free_i < thr_bytes(tx_request_threshold_i) |=>
            !tx_irq_req_o && !tx_dma_req_o)
        else $error("tx request held after condition lapsed");

    a_rx_four_no_dma : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        rx_request_threshold_i == THR_CODE_FOUR |=>
            !rx_dma_req_o)
        else $error("rx dma request on interrupt-only code");

    a_tx_small_no_dma : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !tx_request_threshold_i[1] |=>
            !tx_dma_req_o)
        else $error("tx dma request on interrupt-only code");

    // dma is a subset of the interrupt condition, never on its own
    a_rx_dma_with_irq : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        rx_dma_req_o |->
            rx_irq_req_o)
        else $error("rx dma request without interrupt request");

    a_tx_dma_with_irq : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        tx_dma_req_o |->
            tx_irq_req_o)
        else $error("tx dma request without interrupt request");

    a_start_one_cycle : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        tx_start_o |=>
            !tx_start_o)
        else $error("start pulse longer than one cycle");

    a_start_needs_shift : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        tx_start_o |->
            $past(tx_shift_ready_i) && $past(tx_buf.out_valid))
        else $error("start without shifter ready or byte");

    // the byte may only move together with a start pulse
    a_byte_holds : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !tx_start_o |->
            tx_byte_o == $past(tx_byte_o))
        else $error("byte changed without a start");

    a_start_cts_ok : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        tx_start_o && $past(clear_to_send_check_i && !auto_flow_enable_i) |->
            !$past(cts_sync_b))
        else $error("start while synced clear-to-send negated");

endmodule

// [design/uft_pkg.sv]
package uft_pkg;

    // ==========================================================
    // fifo level counts (16-deep fifos, 0..16)
    localparam int unsigned LVL_W = 5;

    // ==========================================================
    // threshold codes
    localparam logic [1:0] THR_CODE_ONE    = 2'h0;
    localparam logic [1:0] THR_CODE_FOUR   = 2'h1;
    localparam logic [1:0] THR_CODE_EIGHT  = 2'h2;
    localparam logic [1:0] THR_CODE_TWELVE = 2'h3;

    // ==========================================================
    // byte counts per threshold code
    localparam logic [LVL_W-1:0] THR_ONE    = 5'h01;
    localparam logic [LVL_W-1:0] THR_FOUR   = 5'h04;
    localparam logic [LVL_W-1:0] THR_EIGHT  = 5'h08;
    localparam logic [LVL_W-1:0] THR_TWELVE = 5'h0c;

    // ==========================================================
    // reset values and buffer shape
    localparam logic       REQ_RST    = 1'h0;
    localparam logic [7:0] BYTE_RST   = 8'h00;
    localparam logic [1:0] CNT_RST    = 2'h0;
    localparam logic [1:0] BUF_DEPTH  = 2'h2;
    localparam int unsigned BYTE_W    = 8;

endpackage

// [design/uft_buf_if.sv]
`timescale 1ns/1ps
interface uft_buf_if;
    import uft_pkg::*;
    logic              in_valid;
    logic              in_ready;
    logic [BYTE_W-1:0] in_data;
    logic              out_valid;
    logic              out_ready;
    logic [BYTE_W-1:0] out_data;

    modport buffer (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user   (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// [design/uft_buf.sv]
`timescale 1ns/1ps
// two-entry buffer; ready and valid come from flops so the
// feeding fifo sees no combinational path through the gate
module uft_buf (
    input  wire logic  clk_i,
    input  wire logic  rst_b_i,
    uft_buf_if.buffer  bus
);
    import uft_pkg::*;

    logic [BYTE_W-1:0] mem [2];
    logic              wr_ptr;
    logic              rd_ptr;
    logic [1:0]        count;
    logic              in_ready_q;
    logic              out_valid_q;
    wire               push = bus.in_valid & in_ready_q;
    wire               pop  = out_valid_q & bus.out_ready;
    wire  [1:0]        next_count = count + {1'b0, push} - {1'b0, pop};

    assign bus.in_ready  = in_ready_q;
    assign bus.out_valid = out_valid_q;
    assign bus.out_data  = mem[rd_ptr];

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr      <= 1'b0;
            rd_ptr      <= 1'b0;
            count       <= CNT_RST;
            in_ready_q  <= 1'b1;
            out_valid_q <= 1'b0;
        end else begin
            wr_ptr      <= wr_ptr ^ push;
            rd_ptr      <= rd_ptr ^ pop;
            count       <= next_count;
            in_ready_q  <= next_count != BUF_DEPTH;
            out_valid_q <= next_count != CNT_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= bus.in_data;
        end
    end

    a_buf_no_over : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        count <= BUF_DEPTH) else $error("buffer count above depth");

endmodule

// [dv/uft_peer_model.sv]
`timescale 1ns/1ps
// ==========================================================
// far side: shifter readiness and the clear-to-send pin
module uft_peer_model (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic tx_start_i,
    input  wire logic cts_hold_i,
    input  wire logic slow_i,
    output logic      shift_ready_o,
    output logic      cts_b_o
);
    logic [3:0] busy;
    // slow mode keeps the shifter busy for several cycles per byte
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy <= 4'h0;
        end else if (tx_start_i) begin
            busy <= slow_i ? 4'h6 : 4'h1;
        end else if (busy != 4'h0) begin
            busy <= busy - 4'h1;
        end
    end
    assign shift_ready_o = (busy == 4'h0);
    // pin is active low: high while the peer refuses bytes
    assign cts_b_o       = cts_hold_i;
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import uft_pkg::*;
    localparam logic [LVL_W-1:0] THR [4] = '{THR_ONE, THR_FOUR, THR_EIGHT, THR_TWELVE};
    logic              clk_i, rst_b_i, cts_chk, afe, cts_b, hold, slow;
    logic              tx_valid, tx_ready, sready, tx_start;
    logic              rx_irq, rx_dma, tx_irq, tx_dma;
    logic [1:0]        rx_thr, tx_thr;
    logic [LVL_W-1:0]  rx_lvl, tx_free;
    logic [BYTE_W-1:0] tx_data, tx_byte;
    logic [BYTE_W-1:0] sent [$];
    int                mismatches, samples_checked, cycles;

    uft_top DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .rx_request_threshold_i(rx_thr),
        .tx_request_threshold_i(tx_thr), .clear_to_send_check_i(cts_chk),
        .auto_flow_enable_i(afe), .rx_level_i(rx_lvl), .tx_free_i(tx_free), .cts_b_i(cts_b),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
        .tx_shift_ready_i(sready), .tx_start_o(tx_start), .tx_byte_o(tx_byte),
        .rx_irq_req_o(rx_irq), .rx_dma_req_o(rx_dma), .tx_irq_req_o(tx_irq),
        .tx_dma_req_o(tx_dma));
    uft_peer_model PEER (.clk_i(clk_i), .rst_b_i(rst_b_i), .tx_start_i(tx_start),
        .cts_hold_i(hold), .slow_i(slow), .shift_ready_o(sready), .cts_b_o(cts_b));

    // ==========================================================
    // clock, launch monitor, hang guard
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (tx_start === 1'b1) sent.push_back(tx_byte);
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            report_and_stop();
        end
    end

    // ==========================================================
    // helpers
    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // leaves valid high so back-to-back bytes never retoggle it
    task automatic send(logic [BYTE_W-1:0] b);
        tx_valid = 1'b1;
        tx_data  = b;
        for (int i = 0; i < 40 && tx_ready !== 1'b1; i++) begin
            @(posedge clk_i); #2;
        end
        @(posedge clk_i); #2;
    endtask
    task automatic wait_launches(int n);
        for (int i = 0; i < 60 && sent.size() < n; i++) @(posedge clk_i);
        #2;
    endtask
    task automatic report_and_stop();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic rx_scan();
        for (int c = 0; c < 4; c++) for (int k = 0; k < 2; k++) begin
            rx_thr = 2'(c);
            rx_lvl = THR[c] - LVL_W'(k);
            @(posedge clk_i); #2;
            chk("rx_irq", rx_irq, k == 0);
            chk("rx_dma", rx_dma, k == 0 && c != 1);
        end
    endtask
    task automatic tx_scan();
        for (int c = 0; c < 4; c++) for (int k = 0; k < 2; k++) begin
            tx_thr  = 2'(c);
            tx_free = THR[c] - LVL_W'(k);
            @(posedge clk_i); #2;
            chk("tx_irq", tx_irq, k == 0);
            chk("tx_dma", tx_dma, k == 0 && c >= 2);
        end
    endtask
    // software side of dma: burst and transmit dma keep to the large codes
    task automatic dma_setup();
        rx_thr  = THR_CODE_EIGHT;
        rx_lvl  = THR_EIGHT;
        tx_thr  = THR_CODE_EIGHT;
        tx_free = THR_EIGHT;
        @(posedge clk_i); #2;
        chk("rx_dma_burst", rx_dma, 1'b1);
        chk("tx_dma_feed", tx_dma, 1'b1);
        rx_thr = THR_CODE_ONE;
        rx_lvl = THR_ONE;
        @(posedge clk_i); #2;
        chk("rx_dma_single", rx_dma, 1'b1);
    endtask
    // peer refuses, buffer fills, then releases with a slow shifter
    task automatic cts_hold_back();
        cts_chk = 1'b1;
        slow    = 1'b1;
        send(8'ha5);
        send(8'h3c);
        tx_valid = 1'b0;
        repeat (10) @(posedge clk_i);
        #2;
        chk("tx_ready_full", tx_ready, 1'b0);
        chk("held_launches", 8'(sent.size()), 8'h00);
        hold = 1'b0;
        wait_launches(2);
        chk("first_byte", sent[0], 8'ha5);
        chk("second_byte", sent[1], 8'h3c);
    endtask
    task automatic autoflow_override();
        hold = 1'b1;
        afe  = 1'b1;
        slow = 1'b0;
        send(8'h5a);
        tx_valid = 1'b0;
        wait_launches(3);
        chk("afe_launches", 8'(sent.size()), 8'h03);
        chk("afe_byte", sent[2], 8'h5a);
    endtask

    initial begin
        {rst_b_i, cts_chk, afe, tx_valid, slow} = '0;
        hold = 1'b1;
        {rx_thr, tx_thr, rx_lvl, tx_free, tx_data} = '0;
        repeat (5) @(posedge clk_i);
        #2;
        chk("reset_ready", tx_ready, 1'b1);
        chk("reset_byte", tx_byte, BYTE_RST);
        chk("reset_reqs", {rx_irq, rx_dma, tx_irq, tx_dma}, 8'h00);
        rst_b_i = 1'b1;
        rx_scan();
        tx_scan();
        dma_setup();
        cts_hold_back();
        autoflow_override();
        report_and_stop();
    end
endmodule
